// File: baafsm_defs.svh
// Constants for the basic access activation state machines
// Assumes a 50 MHz mclk; included by the package and the design modules
`ifndef BAAFSM_DEFS_SVH
`define BAAFSM_DEFS_SVH

// Line signal codes (INFO 0..4)
`define BAA_INFO0 3'h0
`define BAA_INFO1 3'h1
`define BAA_INFO2 3'h2
`define BAA_INFO3 3'h3
`define BAA_INFO4 3'h4
`define BAA_INFO_W 3

// Channel structure: two B channels, one D channel at 16 kbit/s
`define BAA_NUM_B 2
`define BAA_D_RATE_KBPS 16

// Clock and timing
`define BAA_CLK_MHZ 50
`define BAA_RX_STABLE_NS 1000
`define BAA_RX_STABLE_CYC ((`BAA_RX_STABLE_NS * `BAA_CLK_MHZ) / 1000)
`define BAA_DEACT_US 1000
`define BAA_DEACT_CYC (`BAA_DEACT_US * `BAA_CLK_MHZ)
`define BAA_CNT_W 20

`endif

// File: baafsm_pkg.sv
// Types shared by the activation state machines
// Assumes baafsm_defs.svh sits in the same folder
`include "baafsm_defs.svh"

package baafsm_pkg;

  // Terminal states, Gray coded along F1..F8
  typedef enum logic [2:0] {
    BAA_F1_INACTIVE = 3'h0,
    BAA_F2_SENSING = 3'h1,
    BAA_F3_DEACT = 3'h3,
    BAA_F4_AWAIT = 3'h2,
    BAA_F5_IDENT = 3'h6,
    BAA_F6_SYNC = 3'h7,
    BAA_F7_ACTIVE = 3'h5,
    BAA_F8_LOSTFR = 3'h4
  } baa_te_state_t;

  // Network states, Gray coded along G1..G4
  typedef enum logic [1:0] {
    BAA_G1_DEACT = 2'h0,
    BAA_G2_PEND_ACT = 2'h1,
    BAA_G3_ACTIVE = 2'h3,
    BAA_G4_PEND_DEACT = 2'h2
  } baa_nt_state_t;

  // What a side has classified on its receive line
  typedef struct packed {
    logic [`BAA_INFO_W-1:0] info;
    logic sig;
    logic framed;
  } baa_rx_t;

  // Status toward management
  typedef struct packed {
    logic activated;
    logic low_power;
    logic tx_on;
  } baa_stat_t;

endpackage : baafsm_pkg

// File: baafsm_rx_qual.sv
// Synchroniser and stability filter for a received line classification
// Assumes rx inputs come from the line receiver outside the mclk domain
`include "baafsm_defs.svh"
`timescale 1ns/1ns

module baafsm_rx_qual (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [`BAA_INFO_W-1:0] rx_info,
  input wire logic rx_sig,
  input wire logic rx_framed,
  output baafsm_pkg::baa_rx_t rx_q
);

  localparam int W = `BAA_INFO_W + 2;
  logic [W-1:0] raw;
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] last_q;
  logic [7:0] cnt_q;

  // Bit order matches the packed receive struct: info, sig, framed
  assign raw = {rx_info, rx_sig, rx_framed};

  // Two flip-flop synchroniser, one per bit
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_sync
      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          s1_q[i] <= 1'b0;
          s2_q[i] <= 1'b0;
        end else begin
          s1_q[i] <= raw[i];
          s2_q[i] <= s1_q[i];
        end
      end
    end
  endgenerate

  // Accept a value only after it held steady
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      last_q <= '0;
      cnt_q <= 8'h00;
      rx_q <= '0;
    end else begin
      last_q <= s2_q;
      if (s2_q != last_q) begin
        cnt_q <= 8'h00;
      end else if (cnt_q < 8'(`BAA_RX_STABLE_CYC)) begin
        cnt_q <= cnt_q + 8'h01;
      end else begin
        rx_q <= s2_q;
      end
    end
  end

endmodule : baafsm_rx_qual

// File: baafsm_timer.sv
// Down counter for the pending-deactivation hold time
// Assumes start is a one-cycle pulse on mclk
`include "baafsm_defs.svh"
`timescale 1ns/1ns

module baafsm_timer (
  input wire logic mclk,
  input wire logic reset,
  input wire logic start,
  input wire logic abort,
  input wire logic [`BAA_CNT_W-1:0] load,
  output logic expired
);

  logic [`BAA_CNT_W-1:0] cnt_q;
  logic run_q;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (start) begin
        cnt_q <= load;
        run_q <= 1'b1;
      end else if (abort) begin
        run_q <= 1'b0;
      end else if (run_q) begin
        if (cnt_q <= `BAA_CNT_W'(1)) begin
          run_q <= 1'b0;
          expired <= 1'b1;
        end else begin
          cnt_q <= cnt_q - `BAA_CNT_W'(1);
        end
      end
    end
  end

endmodule : baafsm_timer

// File: baafsm_top.sv
// Terminal (F1..F8) and network (G1..G4) activation state machines
// Assumes rx classifications arrive asynchronously; requests are mclk pulses
`include "baafsm_defs.svh"
`timescale 1ns/1ns

module baafsm_top #(
  parameter logic [`BAA_CNT_W-1:0] DEACT_CYC = `BAA_CNT_W'(`BAA_DEACT_CYC)
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic te_power_ok,
  input wire logic te_src_ok,
  input wire logic te_ph_act_req,
  input wire logic [`BAA_INFO_W-1:0] te_rx_info,
  input wire logic te_rx_sig,
  input wire logic te_rx_framed,
  output logic [`BAA_INFO_W-1:0] te_tx_info,
  output logic te_tx_en,
  output logic te_data_en,
  output baafsm_pkg::baa_stat_t te_stat,
  output baafsm_pkg::baa_te_state_t te_state,
  input wire logic nt_ph_act_req,
  input wire logic nt_mph_deact_req,
  input wire logic nt_hold_deact,
  input wire logic [`BAA_INFO_W-1:0] nt_rx_info,
  input wire logic nt_rx_sig,
  input wire logic nt_rx_framed,
  output logic [`BAA_INFO_W-1:0] nt_tx_info,
  output logic nt_tx_en,
  output logic nt_data_en,
  output baafsm_pkg::baa_stat_t nt_stat,
  output baafsm_pkg::baa_nt_state_t nt_state
);

  baafsm_pkg::baa_rx_t te_rx;
  baafsm_pkg::baa_rx_t nt_rx;
  baafsm_pkg::baa_te_state_t te_d;
  baafsm_pkg::baa_nt_state_t nt_d;
  logic pwr_s1_q;
  logic pwr_q;
  logic src_s1_q;
  logic src_q;
  logic tmr_start;
  logic tmr_abort;
  logic tmr_expired;

  // ------------------------------------------------------------
  // Receive qualification
  // ------------------------------------------------------------
  baafsm_rx_qual u_te_rx (
    .mclk(mclk),
    .reset(reset),
    .rx_info(te_rx_info),
    .rx_sig(te_rx_sig),
    .rx_framed(te_rx_framed),
    .rx_q(te_rx)
  );

  baafsm_rx_qual u_nt_rx (
    .mclk(mclk),
    .reset(reset),
    .rx_info(nt_rx_info),
    .rx_sig(nt_rx_sig),
    .rx_framed(nt_rx_framed),
    .rx_q(nt_rx)
  );

  // ------------------------------------------------------------
  // Power sense synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pwr_s1_q <= 1'b0;
      pwr_q <= 1'b0;
      src_s1_q <= 1'b0;
      src_q <= 1'b0;
    end else begin
      pwr_s1_q <= te_power_ok;
      pwr_q <= pwr_s1_q;
      src_s1_q <= te_src_ok;
      src_q <= src_s1_q;
    end
  end

  // ------------------------------------------------------------
  // Terminal state machine
  // ------------------------------------------------------------
  always_comb begin
    te_d = te_state;
    case (te_state)
      baafsm_pkg::BAA_F1_INACTIVE: begin
        if (pwr_q && src_q) begin
          te_d = baafsm_pkg::BAA_F2_SENSING;
        end
      end
      baafsm_pkg::BAA_F2_SENSING: begin
        if (!te_rx.sig || te_rx.info == `BAA_INFO0) begin
          te_d = baafsm_pkg::BAA_F3_DEACT;
        end else if (te_rx.info == `BAA_INFO2) begin
          te_d = baafsm_pkg::BAA_F6_SYNC;
        end else if (te_rx.info == `BAA_INFO4 && te_rx.framed) begin
          te_d = baafsm_pkg::BAA_F7_ACTIVE;
        end
      end
      baafsm_pkg::BAA_F3_DEACT: begin
        if (te_rx.sig && te_rx.info == `BAA_INFO2) begin
          te_d = baafsm_pkg::BAA_F6_SYNC;
        end else if (te_rx.sig && te_rx.info == `BAA_INFO4 && te_rx.framed) begin
          te_d = baafsm_pkg::BAA_F7_ACTIVE;
        end else if (te_ph_act_req) begin
          te_d = baafsm_pkg::BAA_F4_AWAIT;
        end
      end
      baafsm_pkg::BAA_F4_AWAIT: begin
        if (te_rx.sig) begin
          te_d = baafsm_pkg::BAA_F5_IDENT;
        end
      end
      baafsm_pkg::BAA_F5_IDENT: begin
        if (te_rx.info == `BAA_INFO2) begin
          te_d = baafsm_pkg::BAA_F6_SYNC;
        end else if (te_rx.info == `BAA_INFO4 && te_rx.framed) begin
          te_d = baafsm_pkg::BAA_F7_ACTIVE;
        end else if (!te_rx.sig) begin
          te_d = baafsm_pkg::BAA_F3_DEACT;
        end
      end
      baafsm_pkg::BAA_F6_SYNC: begin
        if (te_rx.info == `BAA_INFO4 && te_rx.framed) begin
          te_d = baafsm_pkg::BAA_F7_ACTIVE;
        end else if (!te_rx.sig || te_rx.info == `BAA_INFO0) begin
          te_d = baafsm_pkg::BAA_F3_DEACT;
        end else if (!te_rx.framed) begin
          te_d = baafsm_pkg::BAA_F8_LOSTFR;
        end
      end
      baafsm_pkg::BAA_F7_ACTIVE: begin
        if (!te_rx.sig || te_rx.info == `BAA_INFO0) begin
          te_d = baafsm_pkg::BAA_F3_DEACT;
        end else if (!te_rx.framed) begin
          te_d = baafsm_pkg::BAA_F8_LOSTFR;
        end else if (te_rx.info == `BAA_INFO2) begin
          te_d = baafsm_pkg::BAA_F6_SYNC;
        end
      end
      baafsm_pkg::BAA_F8_LOSTFR: begin
        if (!te_rx.sig || te_rx.info == `BAA_INFO0) begin
          te_d = baafsm_pkg::BAA_F3_DEACT;
        end else if (te_rx.framed && te_rx.info == `BAA_INFO2) begin
          te_d = baafsm_pkg::BAA_F6_SYNC;
        end else if (te_rx.framed && te_rx.info == `BAA_INFO4) begin
          te_d = baafsm_pkg::BAA_F7_ACTIVE;
        end
      end
      default: begin
        te_d = baafsm_pkg::BAA_F1_INACTIVE;
      end
    endcase
    if (!pwr_q || !src_q) begin
      te_d = baafsm_pkg::BAA_F1_INACTIVE;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      te_state <= baafsm_pkg::BAA_F1_INACTIVE;
    end else begin
      te_state <= te_d;
    end
  end

  // Terminal line output and status, registered
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      te_tx_info <= `BAA_INFO0;
      te_tx_en <= 1'b0;
      te_data_en <= 1'b0;
      te_stat <= '0;
    end else begin
      te_tx_info <= `BAA_INFO0;
      te_tx_en <= 1'b0;
      case (te_d)
        baafsm_pkg::BAA_F4_AWAIT: begin
          te_tx_info <= `BAA_INFO1;
          te_tx_en <= 1'b1;
        end
        baafsm_pkg::BAA_F6_SYNC, baafsm_pkg::BAA_F7_ACTIVE: begin
          te_tx_info <= `BAA_INFO3;
          te_tx_en <= 1'b1;
        end
        default: begin
          te_tx_info <= `BAA_INFO0;
        end
      endcase
      te_data_en <= (te_d == baafsm_pkg::BAA_F7_ACTIVE);
      te_stat.activated <= (te_d == baafsm_pkg::BAA_F7_ACTIVE);
      te_stat.low_power <= (te_d == baafsm_pkg::BAA_F2_SENSING) ||
                           (te_d == baafsm_pkg::BAA_F3_DEACT);
      te_stat.tx_on <= (te_d == baafsm_pkg::BAA_F4_AWAIT) ||
                       (te_d == baafsm_pkg::BAA_F6_SYNC) ||
                       (te_d == baafsm_pkg::BAA_F7_ACTIVE);
    end
  end

  // ------------------------------------------------------------
  // Network state machine
  // ------------------------------------------------------------
  // INFO 3 from any number of terminals reads as one signal
  always_comb begin
    nt_d = nt_state;
    case (nt_state)
      baafsm_pkg::BAA_G1_DEACT: begin
        if (nt_ph_act_req || (nt_rx.sig && nt_rx.info == `BAA_INFO1)) begin
          nt_d = baafsm_pkg::BAA_G2_PEND_ACT;
        end
      end
      baafsm_pkg::BAA_G2_PEND_ACT: begin
        if (nt_mph_deact_req) begin
          nt_d = baafsm_pkg::BAA_G4_PEND_DEACT;
        end else if (nt_rx.sig && nt_rx.framed && nt_rx.info == `BAA_INFO3) begin
          nt_d = baafsm_pkg::BAA_G3_ACTIVE;
        end
      end
      baafsm_pkg::BAA_G3_ACTIVE: begin
        if (nt_mph_deact_req) begin
          nt_d = baafsm_pkg::BAA_G4_PEND_DEACT;
        end else if (!nt_rx.sig || nt_rx.info == `BAA_INFO0 || !nt_rx.framed) begin
          nt_d = baafsm_pkg::BAA_G2_PEND_ACT;
        end
      end
      baafsm_pkg::BAA_G4_PEND_DEACT: begin
        if (tmr_expired || !nt_hold_deact) begin
          nt_d = baafsm_pkg::BAA_G1_DEACT;
        end
      end
      default: begin
        nt_d = baafsm_pkg::BAA_G1_DEACT;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      nt_state <= baafsm_pkg::BAA_G1_DEACT;
    end else begin
      nt_state <= nt_d;
    end
  end

  assign tmr_start = (nt_d == baafsm_pkg::BAA_G4_PEND_DEACT) &&
                     (nt_state != baafsm_pkg::BAA_G4_PEND_DEACT);
  assign tmr_abort = (nt_state != baafsm_pkg::BAA_G4_PEND_DEACT);

  baafsm_timer u_deact_tmr (
    .mclk(mclk),
    .reset(reset),
    .start(tmr_start),
    .abort(tmr_abort),
    .load(DEACT_CYC),
    .expired(tmr_expired)
  );

  // Network line output and status, registered
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      nt_tx_info <= `BAA_INFO0;
      nt_tx_en <= 1'b0;
      nt_data_en <= 1'b0;
      nt_stat <= '0;
    end else begin
      case (nt_d)
        baafsm_pkg::BAA_G2_PEND_ACT: begin
          nt_tx_info <= `BAA_INFO2;
          nt_tx_en <= 1'b1;
        end
        baafsm_pkg::BAA_G3_ACTIVE: begin
          nt_tx_info <= `BAA_INFO4;
          nt_tx_en <= 1'b1;
        end
        default: begin
          nt_tx_info <= `BAA_INFO0;
          nt_tx_en <= 1'b0;
        end
      endcase
      nt_data_en <= (nt_d == baafsm_pkg::BAA_G3_ACTIVE);
      nt_stat.activated <= (nt_d == baafsm_pkg::BAA_G3_ACTIVE);
      nt_stat.low_power <= (nt_d == baafsm_pkg::BAA_G1_DEACT);
      nt_stat.tx_on <= (nt_d == baafsm_pkg::BAA_G2_PEND_ACT) ||
                       (nt_d == baafsm_pkg::BAA_G3_ACTIVE);
    end
  end

endmodule : baafsm_top

// File: baafsm_chk_sva.sv
// Concurrent checks on the ports of the activation state machines
// Assumes it is bound into baafsm_top and sees only that module's ports
`include "baafsm_defs.svh"
`timescale 1ns/1ns

module baafsm_chk #(
  parameter logic [`BAA_CNT_W-1:0] DEACT_CYC = `BAA_CNT_W'(8)
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic te_power_ok,
  input wire logic te_ph_act_req,
  input wire logic [`BAA_INFO_W-1:0] te_tx_info,
  input wire logic te_tx_en,
  input wire logic te_data_en,
  input baafsm_pkg::baa_te_state_t te_state,
  input wire logic nt_ph_act_req,
  input wire logic nt_mph_deact_req,
  input wire logic nt_hold_deact,
  input wire logic [`BAA_INFO_W-1:0] nt_tx_info,
  input wire logic nt_tx_en,
  input baafsm_pkg::baa_nt_state_t nt_state
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // ----------------------------------------
  // Deactivation steps
  // ----------------------------------------
  sequence deact_taken;
    nt_mph_deact_req && nt_state == baafsm_pkg::BAA_G3_ACTIVE;
  endsequence
  sequence deact_held;
    deact_taken ##1 nt_state == baafsm_pkg::BAA_G4_PEND_DEACT && nt_hold_deact;
  endsequence

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  reset_base_a: assert property ($fell(reset) |-> te_state == baafsm_pkg::BAA_F1_INACTIVE
    && nt_state == baafsm_pkg::BAA_G1_DEACT && !te_tx_en && !nt_tx_en)
    else $error("state after reset wrong");
  te_quiet_a: assert property (te_state == baafsm_pkg::BAA_F1_INACTIVE |-> !te_tx_en)
    else $error("inactive terminal drives line");
  power_loss_a: assert property ($fell(te_power_ok) |-> ##[1:4]
    te_state == baafsm_pkg::BAA_F1_INACTIVE) else $error("power loss not honoured");
  act_start_a: assert property (te_ph_act_req && te_state == baafsm_pkg::BAA_F3_DEACT
    |=> te_state != baafsm_pkg::BAA_F3_DEACT) else $error("activate request lost");
  send_one_a: assert property (te_state == baafsm_pkg::BAA_F4_AWAIT |-> te_tx_en
    && te_tx_info == `BAA_INFO1) else $error("no INFO 1 while awaiting");
  ident_stop_a: assert property (te_state == baafsm_pkg::BAA_F5_IDENT
    |-> !(te_tx_en && te_tx_info == `BAA_INFO1)) else $error("INFO 1 while identifying");
  te_three_a: assert property (te_state inside {baafsm_pkg::BAA_F6_SYNC,
    baafsm_pkg::BAA_F7_ACTIVE} |-> te_tx_en && te_tx_info == `BAA_INFO3)
    else $error("terminal not sending INFO 3");
  data_gate_a: assert property (te_data_en == (te_state == baafsm_pkg::BAA_F7_ACTIVE))
    else $error("terminal data outside activated");
  nt_quiet_a: assert property (nt_state == baafsm_pkg::BAA_G1_DEACT |-> !nt_tx_en)
    else $error("deactivated network drives line");
  nt_two_a: assert property (nt_state == baafsm_pkg::BAA_G2_PEND_ACT |-> nt_tx_en
    && nt_tx_info == `BAA_INFO2) else $error("no INFO 2 while pending");
  nt_four_a: assert property (nt_state == baafsm_pkg::BAA_G3_ACTIVE |-> nt_tx_en
    && nt_tx_info == `BAA_INFO4) else $error("no INFO 4 while active");
  nt_act_a: assert property (nt_ph_act_req && nt_state == baafsm_pkg::BAA_G1_DEACT
    |=> nt_state == baafsm_pkg::BAA_G2_PEND_ACT) else $error("network request lost");
  deact_go_a: assert property (deact_taken |=> nt_state == baafsm_pkg::BAA_G4_PEND_DEACT)
    else $error("deactivate request lost");
  hold_wait_a: assert property (deact_held |=> nt_state == baafsm_pkg::BAA_G4_PEND_DEACT [*4])
    else $error("pending deactivation cut short");
  quick_exit_a: assert property (nt_state == baafsm_pkg::BAA_G4_PEND_DEACT
    && !nt_hold_deact |=> nt_state == baafsm_pkg::BAA_G1_DEACT) else $error("no quick exit");
endmodule : baafsm_chk

bind baafsm_top baafsm_chk #(.DEACT_CYC(DEACT_CYC)) u_chk (.mclk(mclk), .reset(reset),
  .te_power_ok(te_power_ok), .te_ph_act_req(te_ph_act_req), .te_tx_info(te_tx_info),
  .te_tx_en(te_tx_en), .te_data_en(te_data_en), .te_state(te_state),
  .nt_ph_act_req(nt_ph_act_req), .nt_mph_deact_req(nt_mph_deact_req),
  .nt_hold_deact(nt_hold_deact), .nt_tx_info(nt_tx_info), .nt_tx_en(nt_tx_en),
  .nt_state(nt_state));

// File: baafsm_line.sv
// Line model carrying each end's transmit code to the other end's receiver
// Assumes both ends' transmitters; frame_cut spoils terminal framing
`include "baafsm_defs.svh"
`timescale 1ns/1ns

module baafsm_line (
  input wire logic [`BAA_INFO_W-1:0] te_tx_info,
  input wire logic te_tx_en,
  input wire logic [`BAA_INFO_W-1:0] nt_tx_info,
  input wire logic nt_tx_en,
  input wire logic frame_cut,
  output logic [`BAA_INFO_W-1:0] te_rx_info,
  output logic te_rx_sig,
  output logic te_rx_framed,
  output logic [`BAA_INFO_W-1:0] nt_rx_info,
  output logic nt_rx_sig,
  output logic nt_rx_framed
);
  // A silent transmitter reads as INFO 0; INFO 1 carries no framing
  assign te_rx_info = nt_tx_en ? nt_tx_info : `BAA_INFO0;
  assign te_rx_sig = nt_tx_en;
  assign te_rx_framed = nt_tx_en && !frame_cut;
  assign nt_rx_info = te_tx_en ? te_tx_info : `BAA_INFO0;
  assign nt_rx_sig = te_tx_en;
  assign nt_rx_framed = te_tx_en && te_tx_info != `BAA_INFO1;
endmodule : baafsm_line

// File: tb.sv
// Self-checking bench: both state machines joined through the line model
// Assumes baafsm_pkg, baafsm_line and the checker are compiled first
`include "baafsm_defs.svh"
`timescale 1ns/1ns

module tb;
  localparam logic [`BAA_CNT_W-1:0] DCYC = `BAA_CNT_W'(8);
  logic mclk, reset, te_power_ok, te_src_ok, te_ph_act_req, nt_ph_act_req;
  logic nt_mph_deact_req, nt_hold_deact, frame_cut, te_rx_sig, te_rx_framed;
  logic nt_rx_sig, nt_rx_framed, te_tx_en, te_data_en, nt_tx_en, nt_data_en, seen_f2;
  logic [`BAA_INFO_W-1:0] te_rx_info, nt_rx_info, te_tx_info, nt_tx_info;
  baafsm_pkg::baa_stat_t te_stat, nt_stat;
  baafsm_pkg::baa_te_state_t te_state;
  baafsm_pkg::baa_nt_state_t nt_state;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;

  baafsm_top #(.DEACT_CYC(DCYC)) dut (.mclk, .reset, .te_power_ok, .te_src_ok,
    .te_ph_act_req, .te_rx_info, .te_rx_sig, .te_rx_framed, .te_tx_info, .te_tx_en,
    .te_data_en, .te_stat, .te_state, .nt_ph_act_req, .nt_mph_deact_req, .nt_hold_deact,
    .nt_rx_info, .nt_rx_sig, .nt_rx_framed, .nt_tx_info, .nt_tx_en, .nt_data_en,
    .nt_stat, .nt_state);
  baafsm_line line (.te_tx_info, .te_tx_en, .nt_tx_info, .nt_tx_en, .frame_cut,
    .te_rx_info, .te_rx_sig, .te_rx_framed, .nt_rx_info, .nt_rx_sig, .nt_rx_framed);

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ----------------------------------------
  // Common tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic wait_te(input baafsm_pkg::baa_te_state_t s);
    int n;
    n = 0;
    while (te_state !== s && n < 800) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("te_state", te_state, s);
  endtask : wait_te

  task automatic wait_nt(input baafsm_pkg::baa_nt_state_t s);
    int n;
    n = 0;
    while (nt_state !== s && n < 800) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("nt_state", nt_state, s);
  endtask : wait_nt

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  always @(posedge mclk) begin
    cycles++;
    if (reset) begin
      seen_f2 <= 1'b0;
    end else if (te_state === baafsm_pkg::BAA_F2_SENSING) begin
      seen_f2 <= 1'b1;
    end
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_power_up();
    repeat (10) @(posedge mclk);
    #1;
    chk("te_state", te_state, baafsm_pkg::BAA_F1_INACTIVE);
    chk("te_tx_en", te_tx_en, 1'b0);
    @(posedge mclk);
    te_power_ok <= 1'b1;
    te_src_ok <= 1'b1;
    wait_te(baafsm_pkg::BAA_F3_DEACT);
    chk("seen_f2", seen_f2, 1'b1);
    chk("te_tx_en", te_tx_en, 1'b0);
    chk("te_low_power", te_stat.low_power, 1'b1);
    chk("nt_tx_en", nt_tx_en, 1'b0);
    chk("nt_low_power", nt_stat.low_power, 1'b1);
  endtask : t_power_up

  task automatic t_te_act();
    @(posedge mclk);
    te_ph_act_req <= 1'b1;
    @(posedge mclk);
    te_ph_act_req <= 1'b0;
    #1;
    chk("te_state", te_state, baafsm_pkg::BAA_F4_AWAIT);
    chk("te_tx_info", te_tx_info, `BAA_INFO1);
    wait_te(baafsm_pkg::BAA_F5_IDENT);
    chk("te_info1", te_tx_en && te_tx_info == `BAA_INFO1, 1'b0);
    wait_te(baafsm_pkg::BAA_F6_SYNC);
    chk("te_tx_info", te_tx_info, `BAA_INFO3);
    wait_te(baafsm_pkg::BAA_F7_ACTIVE);
    chk("te_data_en", te_data_en, 1'b1);
    wait_nt(baafsm_pkg::BAA_G3_ACTIVE);
    chk("nt_tx_info", nt_tx_info, `BAA_INFO4);
    chk("nt_data_en", nt_data_en, 1'b1);
    chk("te_activated", te_stat.activated, 1'b1);
    chk("nt_activated", nt_stat.activated, 1'b1);
    chk("te_tx_on", te_stat.tx_on, 1'b1);
    chk("nt_tx_on", nt_stat.tx_on, 1'b1);
  endtask : t_te_act

  task automatic t_lost_frame();
    @(posedge mclk);
    frame_cut <= 1'b1;
    wait_te(baafsm_pkg::BAA_F8_LOSTFR);
    chk("te_data_en", te_data_en, 1'b0);
    wait_nt(baafsm_pkg::BAA_G2_PEND_ACT);
    chk("nt_tx_info", nt_tx_info, `BAA_INFO2);
    @(posedge mclk);
    frame_cut <= 1'b0;
    wait_te(baafsm_pkg::BAA_F7_ACTIVE);
    wait_nt(baafsm_pkg::BAA_G3_ACTIVE);
  endtask : t_lost_frame

  task automatic t_deact_hold();
    int n;
    @(posedge mclk);
    nt_hold_deact <= 1'b1;
    nt_mph_deact_req <= 1'b1;
    @(posedge mclk);
    nt_mph_deact_req <= 1'b0;
    #1;
    chk("nt_state", nt_state, baafsm_pkg::BAA_G4_PEND_DEACT);
    chk("nt_tx_en", nt_tx_en, 1'b0);
    n = 0;
    while (nt_state === baafsm_pkg::BAA_G4_PEND_DEACT && n < 100) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("hold_long", n >= int'(DCYC), 1'b1);
    chk("hold_short", n <= int'(DCYC) + 3, 1'b1);
    wait_nt(baafsm_pkg::BAA_G1_DEACT);
    chk("nt_data_en", nt_data_en, 1'b0);
    chk("nt_activated", nt_stat.activated, 1'b0);
    chk("nt_low_power", nt_stat.low_power, 1'b1);
    wait_te(baafsm_pkg::BAA_F3_DEACT);
    chk("te_activated", te_stat.activated, 1'b0);
    chk("te_tx_on", te_stat.tx_on, 1'b0);
  endtask : t_deact_hold

  task automatic t_nt_act_power();
    @(posedge mclk);
    nt_hold_deact <= 1'b0;
    nt_ph_act_req <= 1'b1;
    @(posedge mclk);
    nt_ph_act_req <= 1'b0;
    #1;
    chk("nt_state", nt_state, baafsm_pkg::BAA_G2_PEND_ACT);
    chk("nt_tx_info", nt_tx_info, `BAA_INFO2);
    wait_te(baafsm_pkg::BAA_F7_ACTIVE);
    wait_nt(baafsm_pkg::BAA_G3_ACTIVE);
    @(posedge mclk);
    te_power_ok <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    chk("te_state", te_state, baafsm_pkg::BAA_F1_INACTIVE);
    chk("te_tx_en", te_tx_en, 1'b0);
    wait_nt(baafsm_pkg::BAA_G2_PEND_ACT);
    @(posedge mclk);
    nt_mph_deact_req <= 1'b1;
    @(posedge mclk);
    nt_mph_deact_req <= 1'b0;
    #1;
    chk("nt_state", nt_state, baafsm_pkg::BAA_G4_PEND_DEACT);
    @(posedge mclk);
    #1;
    chk("nt_state", nt_state, baafsm_pkg::BAA_G1_DEACT);
    @(posedge mclk);
    te_power_ok <= 1'b1;
    wait_te(baafsm_pkg::BAA_F3_DEACT);
    @(posedge mclk);
    te_src_ok <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    chk("te_state", te_state, baafsm_pkg::BAA_F1_INACTIVE);
  endtask : t_nt_act_power

  initial begin
    reset = 1'b1;
    {te_power_ok, te_src_ok, te_ph_act_req, nt_ph_act_req} = 4'h0;
    {nt_mph_deact_req, nt_hold_deact, frame_cut} = 3'h0;
    repeat (16) @(posedge mclk);
    #1;
    chk("te_state", te_state, baafsm_pkg::BAA_F1_INACTIVE);
    chk("nt_state", nt_state, baafsm_pkg::BAA_G1_DEACT);
    chk("tx_en", {te_tx_en, nt_tx_en}, 2'h0);
    @(posedge mclk);
    reset <= 1'b0;
    t_power_up();
    t_te_act();
    t_lost_frame();
    t_deact_hold();
    t_nt_act_power();
    results();
  end
endmodule : tb
